/* File: ccr_pkg.sv */
package ccr_pkg;
	// Register indexes; each register owns one word at four times its index.
	localparam logic [11:0] CCR_OPTION_IDX = 12'h200;
	localparam logic [11:0] CCR_STATUS_IDX = 12'h202;
	localparam logic [11:0] CCR_PINREP_IDX = 12'h204;
	localparam logic [11:0] CCR_SOCKET_IDX = 12'h206;
	// Extra control and status word for the signals the card register map lacks.
	localparam logic [11:0] CCR_CTRL_IDX = 12'h208;
	// Byte addresses on the AHB-Lite register port, so no two registers share a word.
	localparam logic [11:0] CCR_OPTION_ADDR = {CCR_OPTION_IDX[9:0], 2'b00};
	localparam logic [11:0] CCR_STATUS_ADDR = {CCR_STATUS_IDX[9:0], 2'b00};
	localparam logic [11:0] CCR_PINREP_ADDR = {CCR_PINREP_IDX[9:0], 2'b00};
	localparam logic [11:0] CCR_SOCKET_ADDR = {CCR_SOCKET_IDX[9:0], 2'b00};
	localparam logic [11:0] CCR_CTRL_ADDR = {CCR_CTRL_IDX[9:0], 2'b00};
	// Reset values.
	localparam logic [7:0] CCR_OPTION_RST = 8'h00;
	localparam logic [7:0] CCR_STATUS_RST = 8'h00;
	localparam logic [7:0] CCR_PINREP_RST = 8'h0C;
	localparam logic [7:0] CCR_SOCKET_RST = 8'h00;
	// Field positions.
	localparam int CCR_SOFT_RESET_BIT_POS = 7;
	localparam int CCR_LEVIRQ_POS = 6;
	localparam int CCR_CHG_POS = 7;
	localparam int CCR_SIGEN_POS = 6;
	localparam int CCR_IO8_POS = 5;
	localparam int CCR_PWD_POS = 2;
	localparam int CCR_INTERRUPT_PENDING_FLAG_POS = 1;
	localparam int CCR_CRDY_POS = 5;
	localparam int CCR_RRDY_POS = 1;
	localparam int CCR_COPY_POS = 4;
	// Writable mask for the status register; fixed read-one bits of the pin replacement register.
	localparam logic [7:0] CCR_STATUS_WMASK = 8'h64;
	localparam logic [7:0] CCR_PINREP_FIXED = 8'h0C;
	// Card mode field encodings.
	localparam logic [5:0] CCR_MODE_MEM = 6'h00;
	localparam logic [5:0] CCR_MODE_CONTIG = 6'h01;
	localparam logic [5:0] CCR_MODE_PRIMARY = 6'h02;
	localparam logic [5:0] CCR_MODE_SECOND = 6'h03;
	// Power state transition time and derived cycle count at 100 MHz.
	localparam int CCR_CLK_MHZ = 100;
	localparam int CCR_PWR_SETTLE_NS = 1000;
	localparam int CCR_PWR_SETTLE_CYC = (CCR_PWR_SETTLE_NS * CCR_CLK_MHZ + 999) / 1000;
	// Internal initialization after a card hard reset.
	localparam int CCR_INIT_NS = 2000;
	localparam int CCR_INIT_CYC = (CCR_INIT_NS * CCR_CLK_MHZ + 999) / 1000;
	// Interrupt pulse width in pulse mode.
	localparam int CCR_IRQ_PULSE_CYC = 4;
	typedef enum logic [1:0] {
		CCR_PS_ACTIVE = 2'b00,
		CCR_PS_ENTER = 2'b01,
		CCR_PS_SLEEP = 2'b11,
		CCR_PS_LEAVE = 2'b10
	} ccr_pwr_t;
endpackage

/* File: ccr_regs.sv */
// The implementer's own choice: register access over AHB-Lite.
`timescale 1ns/10ps
module ccr_regs
	import ccr_pkg::*;
#(
	parameter int PWR_SETTLE_CYC = CCR_PWR_SETTLE_CYC,
	parameter int INIT_CYC = CCR_INIT_CYC
) (
	// Clock and reset.
	input wire logic hclk,
	input wire logic hresetn,
	// AHB-Lite slave.
	input wire logic hsel,
	input wire logic [11:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// Card core.
	input wire logic true_ide_mode,
	input wire logic int_request,
	input wire logic interrupt_enable_control,
	input wire logic [11:0] task_addr,
	input wire logic task_io_cycle,
	// Card pins and core controls.
	output logic card_reset,
	output logic init_busy,
	output logic status_change_pin_n,
	output logic interrupt_request_pin_n,
	output logic ready_pin,
	output logic task_hit,
	output logic sleep_mode,
	output logic copy_number,
	output logic [5:0] card_mode
);
	import ccr_pkg::*;

	logic [7:0] option;
	logic status_change_enable;
	logic eight_bit_io_only;
	logic power_down_request;
	logic ready_change_latch;
	logic copy_number_bit;
	logic wr_pend;
	logic [11:0] wr_addr;
	logic rd_pend;
	logic [11:0] rd_addr;
	logic core_rst;
	logic [15:0] init_cnt;
	logic [15:0] pwr_cnt;
	ccr_pwr_t pwr_state;
	logic ready_prev;
	logic int_prev;
	logic [2:0] pulse_cnt;
	logic interrupt_pending_flag;
	logic io_mode;
	logic soft_reset_bit;

	assign soft_reset_bit = option[CCR_SOFT_RESET_BIT_POS];
	assign card_mode = option[5:0];
	assign io_mode = card_mode != CCR_MODE_MEM;
	assign copy_number = copy_number_bit;
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;

	// Bus address phase capture; registers vanish while in true IDE mode.
	wire addr_ok = hsel && hready && htrans[1] && !true_ide_mode;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend <= 1'b0;
			rd_pend <= 1'b0;
			wr_addr <= 12'h000;
			rd_addr <= 12'h000;
		end else begin
			wr_pend <= addr_ok && hwrite;
			rd_pend <= addr_ok && !hwrite;
			wr_addr <= haddr;
			rd_addr <= haddr;
		end
	end

	function automatic logic hit(input logic [11:0] a, input logic [11:0] r);
		hit = a[11:2] == r[11:2];
	endfunction

	wire w_opt = wr_pend && hit(wr_addr, CCR_OPTION_ADDR);
	wire w_sts = wr_pend && hit(wr_addr, CCR_STATUS_ADDR);
	wire w_pin = wr_pend && hit(wr_addr, CCR_PINREP_ADDR);
	wire w_sck = wr_pend && hit(wr_addr, CCR_SOCKET_ADDR);

	// Card hard reset: held while the soft reset bit stays set.
	assign core_rst = soft_reset_bit;
	assign card_reset = core_rst;

	// Option register; the mode field is cleared by a reset in every cycle without a host write to the option register.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			option <= CCR_OPTION_RST;
		end else if (w_opt) begin
			option <= hwdata[7:0];
		end else if (core_rst) begin
			option[5:0] <= CCR_MODE_MEM;
		end
	end

	// Status and socket fields; cleared by a card hard reset too.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			status_change_enable <= 1'b0;
			eight_bit_io_only <= 1'b0;
			power_down_request <= 1'b0;
			copy_number_bit <= 1'b0;
		end else if (core_rst) begin
			status_change_enable <= 1'b0;
			eight_bit_io_only <= 1'b0;
			power_down_request <= 1'b0;
			copy_number_bit <= 1'b0;
		end else begin
			if (w_sts) begin
				status_change_enable <= hwdata[CCR_SIGEN_POS];
				eight_bit_io_only <= hwdata[CCR_IO8_POS];
				power_down_request <= hwdata[CCR_PWD_POS];
			end
			if (w_sck) begin
				copy_number_bit <= hwdata[CCR_COPY_POS];
			end
		end
	end

	// Internal initialization timer after any card hard reset.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			init_cnt <= 16'(INIT_CYC);
		end else if (core_rst) begin
			init_cnt <= 16'(INIT_CYC);
		end else if (init_cnt != 16'h0000) begin
			init_cnt <= init_cnt - 16'h0001;
		end
	end
	assign init_busy = init_cnt != 16'h0000;

	// Power state walk; ready drops on every change of the request.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pwr_state <= CCR_PS_ACTIVE;
			pwr_cnt <= 16'h0000;
		end else begin
			case (pwr_state)
				CCR_PS_ACTIVE: begin
					if (power_down_request) begin
						pwr_state <= CCR_PS_ENTER;
						pwr_cnt <= 16'(PWR_SETTLE_CYC);
					end
				end
				CCR_PS_ENTER: begin
					if (!power_down_request) begin
						pwr_state <= CCR_PS_LEAVE;
						pwr_cnt <= 16'(PWR_SETTLE_CYC);
					end else if (pwr_cnt <= 16'h0001) begin
						pwr_state <= CCR_PS_SLEEP;
					end else begin
						pwr_cnt <= pwr_cnt - 16'h0001;
					end
				end
				CCR_PS_SLEEP: begin
					if (!power_down_request) begin
						pwr_state <= CCR_PS_LEAVE;
						pwr_cnt <= 16'(PWR_SETTLE_CYC);
					end
				end
				CCR_PS_LEAVE: begin
					if (power_down_request) begin
						pwr_state <= CCR_PS_ENTER;
						pwr_cnt <= 16'(PWR_SETTLE_CYC);
					end else if (pwr_cnt <= 16'h0001) begin
						pwr_state <= CCR_PS_ACTIVE;
					end else begin
						pwr_cnt <= pwr_cnt - 16'h0001;
					end
				end
				default: begin
					pwr_state <= CCR_PS_ACTIVE;
				end
			endcase
		end
	end
	assign sleep_mode = pwr_state == CCR_PS_SLEEP;
	// Ready also waits for initialization; a pending request change counts as busy.
	wire pwr_settled = (pwr_state == CCR_PS_ACTIVE && !power_down_request)
		|| (pwr_state == CCR_PS_SLEEP && power_down_request);
	assign ready_pin = pwr_settled && !init_busy && !core_rst;

	// Ready-change latch: a hardware set wins over a host clear.
	wire ready_changed = ready_pin != ready_prev;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ready_prev <= 1'b0;
			ready_change_latch <= 1'b0;
		end else begin
			ready_prev <= ready_pin;
			if (ready_changed) begin
				ready_change_latch <= 1'b1;
			end else if (w_pin && hwdata[CCR_RRDY_POS]) begin
				ready_change_latch <= hwdata[CCR_CRDY_POS];
			end
		end
	end

	// Status change pin, open drain style active low.
	assign status_change_pin_n = !(io_mode && status_change_enable && ready_change_latch);

	// Interrupt flag and request pin.
	assign interrupt_pending_flag = int_request && interrupt_enable_control;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			int_prev <= 1'b0;
			pulse_cnt <= 3'h0;
		end else begin
			int_prev <= interrupt_pending_flag;
			if (interrupt_pending_flag && !int_prev) begin
				pulse_cnt <= 3'(CCR_IRQ_PULSE_CYC);
			end else if (pulse_cnt != 3'h0) begin
				pulse_cnt <= pulse_cnt - 3'h1;
			end
		end
	end
	wire irq_level = option[CCR_LEVIRQ_POS] ? interrupt_pending_flag : (pulse_cnt != 3'h0);
	assign interrupt_request_pin_n = !(io_mode && irq_level);

	// Task file decode for the selected mapping.
	always_comb begin
		task_hit = 1'b0;
		case (card_mode)
			CCR_MODE_MEM: begin
				task_hit = !task_io_cycle && (task_addr[11:4] == 8'h00
					|| task_addr[11:10] == 2'b01);
			end
			CCR_MODE_CONTIG: begin
				task_hit = task_io_cycle;
			end
			CCR_MODE_PRIMARY: begin
				task_hit = task_io_cycle && (task_addr[11:3] == 9'h03E
					|| task_addr[11:1] == 11'h1FB);
			end
			CCR_MODE_SECOND: begin
				task_hit = task_io_cycle && (task_addr[11:3] == 9'h02E
					|| task_addr[11:1] == 11'h1BB);
			end
			default: begin
				task_hit = 1'b0;
			end
		endcase
	end

	// Read data; fixed bits read fixed values, unmapped reads give zero.
	logic [7:0] rd_byte;
	always_comb begin
		rd_byte = 8'h00;
		if (hit(rd_addr, CCR_OPTION_ADDR)) begin
			rd_byte = option;
		end else if (hit(rd_addr, CCR_STATUS_ADDR)) begin
			rd_byte[CCR_CHG_POS] = ready_change_latch;
			rd_byte[CCR_SIGEN_POS] = status_change_enable;
			rd_byte[CCR_IO8_POS] = eight_bit_io_only;
			rd_byte[CCR_PWD_POS] = power_down_request;
			rd_byte[CCR_INTERRUPT_PENDING_FLAG_POS] = interrupt_pending_flag;
		end else if (hit(rd_addr, CCR_PINREP_ADDR)) begin
			rd_byte = CCR_PINREP_FIXED;
			rd_byte[CCR_CRDY_POS] = ready_change_latch;
			rd_byte[CCR_RRDY_POS] = ready_pin;
		end else if (hit(rd_addr, CCR_SOCKET_ADDR)) begin
			rd_byte[CCR_COPY_POS] = copy_number_bit;
		end else if (hit(rd_addr, CCR_CTRL_ADDR)) begin
			rd_byte = {4'h0, sleep_mode, init_busy, core_rst, ready_pin};
		end
	end
	assign hrdata = rd_pend ? {24'h000000, rd_byte} : 32'h00000000;

	// Assertions.
	a_srst_holds: assert property (@(posedge hclk) disable iff (!hresetn)
		core_rst |=> card_mode == CCR_MODE_MEM || $past(w_opt))
		else $error("mode field not cleared under soft reset");
	a_srst_sticky: assert property (@(posedge hclk) disable iff (!hresetn)
		soft_reset_bit && !w_opt |=> soft_reset_bit)
		else $error("soft reset bit cleared itself");
	a_status_change_pin_pin: assert property (@(posedge hclk) disable iff (!hresetn)
		!status_change_pin_n == (io_mode && status_change_enable && ready_change_latch))
		else $error("status change pin wrong");
	sequence s_ready_toggle;
		ready_pin != $past(ready_pin);
	endsequence
	a_crdy_set: assert property (@(posedge hclk) disable iff (!hresetn)
		s_ready_toggle |=> ready_change_latch)
		else $error("ready change not latched");
	a_pwd_busy: assert property (@(posedge hclk) disable iff (!hresetn)
		power_down_request != $past(power_down_request) |-> !ready_pin)
		else $error("ready while power change pending");
	a_interrupt_pending_flag_gate: assert property (@(posedge hclk) disable iff (!hresetn)
		!interrupt_enable_control |-> !interrupt_pending_flag)
		else $error("interrupt flag visible while disabled");
	a_pulse_width: assert property (@(posedge hclk) disable iff (!hresetn)
		!option[CCR_LEVIRQ_POS] && io_mode && $rose(pulse_cnt != 3'h0)
		|-> !interrupt_request_pin_n [*4] ##1 interrupt_request_pin_n)
		else $error("pulse interrupt width wrong");
	a_sleep_reach: assert property (@(posedge hclk) disable iff (!hresetn)
		pwr_state == CCR_PS_ACTIVE && power_down_request && !core_rst
		|-> ##[1:200] (sleep_mode || !power_down_request))
		else $error("sleep state not reached");
	a_primary_hit: assert property (@(posedge hclk) disable iff (!hresetn)
		card_mode == CCR_MODE_PRIMARY && task_io_cycle && task_addr == 12'h1F0 |-> task_hit)
		else $error("primary decode missed");
	a_pin_fixed: assert property (@(posedge hclk) disable iff (!hresetn)
		hit(rd_addr, CCR_PINREP_ADDR) |-> rd_byte[3:2] == 2'b11)
		else $error("fixed pin replacement bits wrong");
endmodule

/* File: ccr_host_model.sv */
`timescale 1ns/10ps
// Behavioural AHB-Lite master standing in for the host socket controller.
module ccr_host_model (
	// Bus clock.
	input wire logic hclk,
	// Slave answer.
	input wire logic hreadyout,
	input wire logic [31:0] hrdata,
	// Master request.
	output logic hsel,
	output logic [11:0] haddr,
	output logic [1:0] htrans,
	output logic hwrite,
	output logic [2:0] hsize,
	output logic [31:0] hwdata
);
	logic stall = 1'b0;
	initial begin
		hsel = 1'b0;
		haddr = 12'h000;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
	end
	// A slave that never answers raises stall instead of hanging the run.
	task automatic wait_ready();
		int n;
		n = 0;
		@(posedge hclk);
		while (hreadyout !== 1'b1 && n < 64) begin
			@(posedge hclk);
			n++;
		end
		if (n >= 64) stall = 1'b1;
	endtask
	task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] wd,
		output logic [31:0] rd);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= wr;
		hsize <= 3'h2;
		wait_ready();
		hsel <= 1'b0;
		htrans <= 2'h0;
		// A deselected address must not keep showing the last value.
		haddr <= ~a;
		hwdata <= wr ? wd : ~hwdata;
		wait_ready();
		rd = hrdata;
		// Released data lines must not keep showing the last value.
		hwdata <= ~wd;
	endtask
endmodule

/* File: card_config_registers_tb_top.sv */
`timescale 1ns/10ps
module card_config_registers_tb_top;
	import ccr_pkg::*;
	localparam int SETTLE = 8;
	localparam int INIT = 6;
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic hsel, hwrite, hreadyout, hresp, true_ide_mode, int_request, interrupt_enable_control;
	logic task_io_cycle, card_reset, init_busy, status_change_pin_n, interrupt_request_pin_n;
	logic ready_pin, task_hit, sleep_mode, copy_number;
	logic [11:0] haddr, task_addr;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic [31:0] hwdata, hrdata;
	logic [5:0] card_mode;
	int err_total = 0;
	int checked = 0;
	int n;
	always #5 hclk = ~hclk;
	ccr_host_model ccr_host_model_i (.hclk(hclk), .hreadyout(hreadyout), .hrdata(hrdata),
		.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hwdata(hwdata));
	ccr_regs #(.PWR_SETTLE_CYC(SETTLE), .INIT_CYC(INIT)) ccr_regs_i (.hclk(hclk),
		.hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .true_ide_mode(true_ide_mode),
		.int_request(int_request), .interrupt_enable_control(interrupt_enable_control),
		.task_addr(task_addr), .task_io_cycle(task_io_cycle), .card_reset(card_reset),
		.init_busy(init_busy), .status_change_pin_n(status_change_pin_n),
		.interrupt_request_pin_n(interrupt_request_pin_n), .ready_pin(ready_pin),
		.task_hit(task_hit), .sleep_mode(sleep_mode), .copy_number(copy_number),
		.card_mode(card_mode));
	task automatic stop_test();
		if (err_total == 0 && checked > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			err_total++;
			$display("Error at %0t ns: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		logic [31:0] r;
		ccr_host_model_i.xfer(1'b1, a, {24'h0, d}, r);
	endtask
	// Reads a register and compares only the bits selected by the mask.
	task automatic rchk(input logic [11:0] a, input logic [7:0] m, input logic [7:0] e);
		logic [31:0] r;
		ccr_host_model_i.xfer(1'b0, a, 32'h0, r);
		check({24'h0, r[7:0] & m}, {24'h0, e});
	endtask
	task automatic await(input int sel, input logic v);
		int k;
		for (k = 0; k < 300; k++) begin
			@(negedge hclk);
			if (sel == 0 ? ready_pin === v : sel == 1 ? sleep_mode === v :
				interrupt_request_pin_n === v) break;
		end
		if (k >= 300) begin
			err_total++;
			stop_test();
		end
		// Hand back on a rising edge so the next request starts there.
		@(posedge hclk);
	endtask
	task automatic hit(input logic [5:0] m, input logic io, input logic [11:0] a, input logic e);
		wr(CCR_OPTION_ADDR, {2'b01, m});
		task_io_cycle <= io;
		task_addr <= a;
		@(negedge hclk);
		check(task_hit, e);
		@(posedge hclk);
	endtask
	initial begin
		true_ide_mode = 1'b0;
		int_request = 1'b0;
		interrupt_enable_control = 1'b1;
		task_addr = 12'h000;
		task_io_cycle = 1'b0;
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		rchk(CCR_OPTION_ADDR, 8'hFF, CCR_OPTION_RST);
		rchk(CCR_STATUS_ADDR, 8'h7F, CCR_STATUS_RST);
		rchk(CCR_PINREP_ADDR, 8'hDD, CCR_PINREP_RST);
		rchk(CCR_SOCKET_ADDR, 8'hFF, CCR_SOCKET_RST);
		await(0, 1'b1);
		rchk(CCR_PINREP_ADDR, 8'h02, 8'h02);
		wr(CCR_SOCKET_ADDR, 8'hFF);
		rchk(CCR_SOCKET_ADDR, 8'hFF, 8'h10);
		check(copy_number, 1'b1);
		hit(CCR_MODE_MEM, 1'b0, 12'h00F, 1'b1);
		hit(CCR_MODE_MEM, 1'b0, 12'h400, 1'b1);
		hit(CCR_MODE_MEM, 1'b0, 12'h010, 1'b0);
		hit(CCR_MODE_CONTIG, 1'b1, 12'h12F, 1'b1);
		hit(CCR_MODE_PRIMARY, 1'b1, 12'h1F7, 1'b1);
		hit(CCR_MODE_PRIMARY, 1'b1, 12'h3F6, 1'b1);
		hit(CCR_MODE_PRIMARY, 1'b1, 12'h1F8, 1'b0);
		hit(CCR_MODE_SECOND, 1'b1, 12'h376, 1'b1);
		hit(CCR_MODE_SECOND, 1'b1, 12'h1F0, 1'b0);
		rchk(CCR_OPTION_ADDR, 8'hFF, 8'h43);
		check(card_mode, CCR_MODE_SECOND);
		// Eight-bit host: sets the narrow bus flag together with sleep and status enable.
		wr(CCR_STATUS_ADDR, 8'hFF);
		rchk(CCR_STATUS_ADDR, 8'h7D, 8'h64);
		rchk(CCR_PINREP_ADDR, 8'h02, 8'h00);
		await(1, 1'b1);
		await(0, 1'b1);
		rchk(CCR_STATUS_ADDR, 8'h80, 8'h80);
		@(negedge hclk);
		check(status_change_pin_n, 1'b0);
		@(posedge hclk);
		wr(CCR_STATUS_ADDR, 8'h20);
		@(negedge hclk);
		check(status_change_pin_n, 1'b1);
		@(posedge hclk);
		await(1, 1'b0);
		await(0, 1'b1);
		wr(CCR_PINREP_ADDR, 8'h00);
		rchk(CCR_PINREP_ADDR, 8'h20, 8'h20);
		wr(CCR_PINREP_ADDR, 8'h02);
		rchk(CCR_STATUS_ADDR, 8'h80, 8'h00);
		int_request <= 1'b1;
		await(2, 1'b0);
		repeat (8) @(posedge hclk);
		@(negedge hclk);
		check(interrupt_request_pin_n, 1'b0);
		@(posedge hclk);
		rchk(CCR_STATUS_ADDR, 8'h02, 8'h02);
		interrupt_enable_control <= 1'b0;
		rchk(CCR_STATUS_ADDR, 8'h02, 8'h00);
		interrupt_enable_control <= 1'b1;
		int_request <= 1'b0;
		wr(CCR_OPTION_ADDR, {2'b00, CCR_MODE_SECOND});
		int_request <= 1'b1;
		await(2, 1'b0);
		n = 0;
		while (interrupt_request_pin_n === 1'b0 && n < 20) begin
			@(negedge hclk);
			n++;
		end
		check(n, CCR_IRQ_PULSE_CYC);
		@(posedge hclk);
		int_request <= 1'b0;
		wr(CCR_OPTION_ADDR, 8'h80);
		@(negedge hclk);
		check(card_reset, 1'b1);
		@(posedge hclk);
		rchk(CCR_OPTION_ADDR, 8'hFF, 8'h80);
		rchk(CCR_SOCKET_ADDR, 8'hFF, 8'h00);
		check(card_mode, CCR_MODE_MEM);
		wr(CCR_OPTION_ADDR, 8'h00);
		@(negedge hclk);
		check(init_busy, 1'b1);
		@(posedge hclk);
		await(0, 1'b1);
		check(card_reset, 1'b0);
		int_request <= 1'b1;
		rchk(CCR_STATUS_ADDR, 8'h02, 8'h02);
		int_request <= 1'b0;
		true_ide_mode <= 1'b1;
		wr(CCR_OPTION_ADDR, 8'h41);
		rchk(CCR_OPTION_ADDR, 8'hFF, 8'h00);
		true_ide_mode <= 1'b0;
		rchk(CCR_OPTION_ADDR, 8'hFF, 8'h00);
		rchk(12'h20C, 8'hFF, 8'h00);
		rchk(CCR_CTRL_ADDR, 8'h0F, 8'h01);
		check(hresp, 1'b0);
		check(ccr_host_model_i.stall, 1'b0);
		stop_test();
	end
endmodule
